// ==== rtctc_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtctc_core #(
  parameter int CRYSTAL_DIV = rtctc_pkg::RTCTC_CRYSTAL_HZ,
  parameter int LINE50_DIV  = rtctc_pkg::RTCTC_LINE50_HZ,
  parameter int LINE60_DIV  = rtctc_pkg::RTCTC_LINE60_HZ
) (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       SRST,
  input  wire logic       PWR_COLD,
  // Processor I/O bus
  input  wire logic [7:0] IO_ADDR,
  input  wire logic [7:0] IO_WDATA,
  input  wire logic       IO_WR,
  input  wire logic       IO_RD,
  output logic      [7:0] IO_RDATA,
  // Count sources
  input  wire logic       OSC_CLK,
  input  wire logic [4:0] MONTH_DAYS,
  // Alarm side
  output logic            CMP_STB,
  output logic            ALARMS_OFF
);
  import rtctc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hrs_q;
  logic [7:0] dow_q;
  logic [7:0] dom_q;
  logic [7:0] rdata_d;
  logic       osc_q;
  logic       osc_rise;
  logic       div_tick;
  logic       ctrl_wr;
  logic       relock_wr;
  logic       unlock;
  logic       bcd;
  logic       advance;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hrs_wrap;
  logic [7:0] sec_last;
  logic [7:0] hrs_last;
  logic [7:0] dom_last;
  logic [7:0] min_step;
  logic [7:0] dom_step;
  logic       wr_sec;
  logic       wr_min;
  logic       wr_hrs;
  logic       wr_dow;
  logic       wr_dom;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One step of a wrapping counter in either number form
  function automatic logic [7:0] rtctc_step(input logic [7:0] v,
                                            input logic [7:0] first,
                                            input logic [7:0] last,
                                            input logic       in_bcd);
    if (v == last)
      return first;
    else if (in_bcd && v[3:0] == RTCTC_BCD_NINE)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return v + RTCTC_ONE;
  endfunction : rtctc_step

  // Binary day count to packed BCD, tens never above three
  function automatic logic [7:0] rtctc_to_bcd(input logic [4:0] b);
    logic [4:0] ones;
    logic [3:0] tens;
    ones = b;
    tens = 4'h0;
    for (int i = 0; i < 3; i++) begin
      if (ones >= 5'd10) begin
        ones = ones - 5'd10;
        tens = tens + 4'h1;
      end
    end
    return {tens, ones[3:0]};
  endfunction : rtctc_to_bcd

  initial begin
    if (LINE50_DIV == LINE60_DIV)
      $error("rtctc_core: line divisors must differ");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Count writes only land while unlocked; locked writes fall away
  assign ctrl_wr   = IO_WR && IO_ADDR == RTCTC_CTRL_ADDR;
  assign relock_wr = ctrl_wr && !IO_WDATA[RTCTC_UNLOCK_BIT];
  assign unlock    = ctrl_q[RTCTC_UNLOCK_BIT];
  assign bcd       = ctrl_q[RTCTC_BCD_BIT];
  assign wr_sec    = IO_WR && unlock && IO_ADDR == RTCTC_SEC_ADDR;
  assign wr_min    = IO_WR && unlock && IO_ADDR == RTCTC_MIN_ADDR;
  assign wr_hrs    = IO_WR && unlock && IO_ADDR == RTCTC_HRS_ADDR;
  assign wr_dow    = IO_WR && unlock && IO_ADDR == RTCTC_DOW_ADDR;
  assign wr_dom    = IO_WR && unlock && IO_ADDR == RTCTC_DOM_ADDR;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Reset always returns to locked, counting, crystal source
  always_ff @(posedge MCLK) begin
    if (SRST)
      ctrl_q <= RTCTC_CTRL_RST;
    else if (ctrl_wr)
      ctrl_q <= IO_WDATA & RTCTC_CTRL_MASK;
  end

  // ----------------------------------------------------------------
  // Source edge and divider
  // ----------------------------------------------------------------
  // Oscillator pin is already synchronous; only its rising edge counts
  always_ff @(posedge MCLK) begin
    // No reset term, so a pin that idles high never fakes an edge
    osc_q <= OSC_CLK;
  end

  assign osc_rise = OSC_CLK && !osc_q;

  // Any control write restarts the phase; relocking also re-enables it
  rtctc_divider #(
    .CRYSTAL_DIV (CRYSTAL_DIV),
    .LINE50_DIV  (LINE50_DIV),
    .LINE60_DIV  (LINE60_DIV)
  ) u_div (
    .clk      (MCLK),
    .srst     (SRST),
    .restart  (ctrl_wr),
    .run      (!unlock),
    .src_line (ctrl_q[RTCTC_SRC_BIT] == 1'(RTCTC_SRC_LINE)),
    .line_50  (ctrl_q[RTCTC_FREQ_BIT]),
    .src_edge (osc_rise),
    .tick     (div_tick)
  );

  // ----------------------------------------------------------------
  // Carry chain
  // ----------------------------------------------------------------
  // Wrap points follow the number form; the month length comes from
  // the calendar outside and is only honoured in BCD form, so binary
  // form runs every month to the 31st
  always_comb begin
    sec_last = bcd ? RTCTC_SEC_LAST_BCD : RTCTC_SEC_LAST_BIN;
    hrs_last = bcd ? RTCTC_HRS_LAST_BCD : RTCTC_HRS_LAST_BIN;
    if (bcd)
      dom_last = rtctc_to_bcd(MONTH_DAYS);
    else
      dom_last = RTCTC_DOM_LAST_BIN;
  end

  // Stray tick during an unlock is dropped, so counting truly stops
  assign advance  = div_tick && !unlock;
  assign sec_wrap = sec_q == sec_last;
  assign min_wrap = sec_wrap && min_q == sec_last;
  assign hrs_wrap = min_wrap && hrs_q == hrs_last;

  // Next values of the carried counters, shared by registers and checks
  assign min_step = rtctc_step(min_q, RTCTC_ZERO, sec_last, bcd);
  assign dom_step = rtctc_step(dom_q, RTCTC_ONE, dom_last, bcd);

  // ----------------------------------------------------------------
  // Time count registers
  // ----------------------------------------------------------------
  // No reset term: the time survives a system reset
  always_ff @(posedge MCLK) begin
    if (wr_sec)
      sec_q <= IO_WDATA;
    else if (advance)
      sec_q <= rtctc_step(sec_q, RTCTC_ZERO, sec_last, bcd);
  end

  // Minutes step on the seconds wrap
  always_ff @(posedge MCLK) begin
    if (wr_min)
      min_q <= IO_WDATA;
    else if (advance && sec_wrap)
      min_q <= min_step;
  end

  // Hours in 24-hour form step on the minutes wrap
  always_ff @(posedge MCLK) begin
    if (wr_hrs)
      hrs_q <= IO_WDATA;
    else if (advance && min_wrap)
      hrs_q <= rtctc_step(hrs_q, RTCTC_ZERO, hrs_last, bcd);
  end

  // Weekday keeps its upper nibble zero even on a wild write
  always_ff @(posedge MCLK) begin
    if (wr_dow)
      dow_q <= IO_WDATA & RTCTC_DOW_MASK;
    else if (advance && hrs_wrap)
      dow_q <= rtctc_step(dow_q, RTCTC_ONE, RTCTC_DOW_LAST, bcd);
  end

  // Month day restarts at one after the last day
  always_ff @(posedge MCLK) begin
    if (wr_dom)
      dom_q <= IO_WDATA;
    else if (advance && hrs_wrap)
      dom_q <= dom_step;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    case (IO_ADDR)
      RTCTC_SEC_ADDR:  rdata_d = sec_q;
      RTCTC_MIN_ADDR:  rdata_d = min_q;
      RTCTC_HRS_ADDR:  rdata_d = hrs_q;
      RTCTC_DOW_ADDR:  rdata_d = dow_q & RTCTC_DOW_MASK;
      RTCTC_DOM_ADDR:  rdata_d = dom_q;
      RTCTC_CTRL_ADDR: rdata_d = ctrl_q;
      default:         rdata_d = RTCTC_ZERO;
    endcase
  end

  // Read data lands one edge after the strobe and then stands
  always_ff @(posedge MCLK) begin
    if (SRST)
      IO_RDATA <= RTCTC_ZERO;
    else if (IO_RD)
      IO_RDATA <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Alarm side
  // ----------------------------------------------------------------
  // Compare request on every advance and on any write that clears unlock
  always_ff @(posedge MCLK) begin
    if (SRST)
      CMP_STB <= 1'b0;
    else
      CMP_STB <= advance || relock_wr;
  end

  // Cold reset disables alarms until software relocks the block
  always_ff @(posedge MCLK) begin
    if (SRST && PWR_COLD)
      ALARMS_OFF <= 1'b1;
    else if (!SRST && relock_wr)
      ALARMS_OFF <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_locked: assert property (@(posedge MCLK)
    SRST |=> ctrl_q == RTCTC_CTRL_RST && !CMP_STB)
    else $error("block not locked after reset");

  a_locked_wr_drop: assert property (@(posedge MCLK) disable iff (SRST)
    (IO_WR && !unlock && IO_ADDR == RTCTC_SEC_ADDR && !advance) |=> $stable(sec_q))
    else $error("locked write changed seconds");

  a_unlocked_hold: assert property (@(posedge MCLK) disable iff (SRST)
    (unlock && !IO_WR) [*2] |=> $stable(sec_q) && $stable(hrs_q))
    else $error("count moved while unlocked");

  a_sec_wrap: assert property (@(posedge MCLK) disable iff (SRST)
    (advance && sec_q == sec_last && !IO_WR) |=> sec_q == RTCTC_ZERO
      && min_q == $past(min_step))
    else $error("seconds wrap or minute carry wrong");

  a_hrs_wrap: assert property (@(posedge MCLK) disable iff (SRST)
    (advance && hrs_wrap && !IO_WR) |=> hrs_q == RTCTC_ZERO
      && dom_q == $past(dom_step))
    else $error("hour wrap or day carry wrong");

  a_dow_nibble: assert property (@(posedge MCLK) disable iff (SRST)
    wr_dow |=> dow_q[7:4] == 4'h0)
    else $error("weekday upper nibble not zero");

  a_relock_cmp: assert property (@(posedge MCLK) disable iff (SRST)
    relock_wr |=> CMP_STB && !ALARMS_OFF)
    else $error("relock did not force a compare");

  a_tick_cmp: assert property (@(posedge MCLK) disable iff (SRST)
    (div_tick && !unlock && !IO_WR) |=> CMP_STB && !$stable(sec_q))
    else $error("locked tick did not advance seconds");

  a_read_data: assert property (@(posedge MCLK) disable iff (SRST)
    (IO_RD && IO_ADDR == RTCTC_CTRL_ADDR && !IO_WR) |=> IO_RDATA == ctrl_q)
    else $error("control read back wrong");

  // Read data stands between strobes
  a_rdata_hold: assert property (@(posedge MCLK) disable iff (SRST)
    !IO_RD |=> $stable(IO_RDATA))
    else $error("read data moved without a read");

  // A frozen count never asks for a compare
  a_unlock_nocmp: assert property (@(posedge MCLK) disable iff (SRST)
    (unlock && !IO_WR) |=> !CMP_STB)
    else $error("compare strobe while unlocked");

  // Divider gives no tick while the block is unlocked
  a_div_stopped: assert property (@(posedge MCLK) disable iff (SRST)
    unlock |=> !div_tick)
    else $error("divider ticked while unlocked");

  // Power-loss reset leaves every alarm disabled
  a_cold_alarms: assert property (@(posedge MCLK)
    (SRST && PWR_COLD) |=> ALARMS_OFF)
    else $error("alarms not disabled by cold reset");

  // Control write lands with its unused bits cleared
  a_ctrl_lands: assert property (@(posedge MCLK) disable iff (SRST)
    ctrl_wr |=> ctrl_q == ($past(IO_WDATA) & RTCTC_CTRL_MASK))
    else $error("control write lost");

  // Unlocked count writes win over a same-cycle advance
  a_sec_lands: assert property (@(posedge MCLK) disable iff (SRST)
    wr_sec |=> sec_q == $past(IO_WDATA))
    else $error("seconds write lost");

  // Minutes write lands whole
  a_min_lands: assert property (@(posedge MCLK) disable iff (SRST)
    wr_min |=> min_q == $past(IO_WDATA))
    else $error("minutes write lost");

  // Hours write lands whole
  a_hrs_lands: assert property (@(posedge MCLK) disable iff (SRST)
    wr_hrs |=> hrs_q == $past(IO_WDATA))
    else $error("hours write lost");

  // Month day write lands whole
  a_dom_lands: assert property (@(posedge MCLK) disable iff (SRST)
    wr_dom |=> dom_q == $past(IO_WDATA))
    else $error("month day write lost");

  // Weekday write lands with its reserved nibble cleared
  a_dow_lands: assert property (@(posedge MCLK) disable iff (SRST)
    wr_dow |=> dow_q == ($past(IO_WDATA) & RTCTC_DOW_MASK))
    else $error("weekday write lost");

endmodule : rtctc_core
`default_nettype wire

// ==== rtctc_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtctc_divider #(
  parameter int CRYSTAL_DIV = 32768,
  parameter int LINE50_DIV  = 50,
  parameter int LINE60_DIV  = 60
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // Control
  input  wire logic          restart,
  input  wire logic          run,
  input  wire logic          src_line,
  input  wire logic          line_50,
  // Source edge and tick out
  input  wire logic          src_edge,
  output logic               tick
);
  import rtctc_pkg::*;

  typedef enum logic {RTCTC_DIV_HOLD, RTCTC_DIV_RUN} rtctc_div_t;

  rtctc_div_t  state_q;
  logic [15:0] count_q;
  logic [15:0] limit;

  initial begin
    if (CRYSTAL_DIV < 2 || CRYSTAL_DIV > 65536 || LINE50_DIV < 2 || LINE60_DIV < 2)
      $error("rtctc_divider: divisor out of range");
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Terminal count for the chosen source
  always_comb begin
    if (src_line)
      limit = line_50 ? 16'(LINE50_DIV - 1) : 16'(LINE60_DIV - 1);
    else
      limit = 16'(CRYSTAL_DIV - 1);
  end

  // Hold while stopped; a restart always begins from phase zero
  always_ff @(posedge clk) begin
    if (srst || restart) begin
      state_q <= RTCTC_DIV_HOLD;
      count_q <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      case (state_q)
        RTCTC_DIV_HOLD: begin
          count_q <= 16'h0000;
          if (run) state_q <= RTCTC_DIV_RUN;
        end
        RTCTC_DIV_RUN: begin
          if (!run) begin
            state_q <= RTCTC_DIV_HOLD;
          end else if (src_edge) begin
            if (count_q >= limit) begin
              count_q <= 16'h0000;
              tick    <= 1'b1;
            end else begin
              count_q <= count_q + 16'h0001;
            end
          end
        end
        default: state_q <= RTCTC_DIV_HOLD;
      endcase
    end
  end

  // Restart must leave the phase at zero
  a_div_restart: assert property (@(posedge clk) disable iff (srst)
    restart |=> (count_q == 16'h0000) && !tick)
    else $error("divider not cleared by restart");

endmodule : rtctc_divider
`default_nettype wire

// ==== rtctc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtctc_host (
  // Clock
  input  wire logic       MCLK,
  // Processor I/O bus
  output logic      [7:0] IO_ADDR,
  output logic      [7:0] IO_WDATA,
  output logic            IO_WR,
  output logic            IO_RD,
  input  wire logic [7:0] IO_RDATA
);
  // Bus idles with both strobes low
  initial begin
    IO_ADDR  = 8'h00;
    IO_WDATA = 8'h00;
    IO_WR    = 1'b0;
    IO_RD    = 1'b0;
  end

  // One strobe cycle, set up on the falling edge and held through the
  // taking edge; address and data then turn to their inverse so a stale
  // value can never pass for a live one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge MCLK);
    IO_ADDR  = a;
    IO_WDATA = d;
    IO_WR    = w;
    IO_RD    = !w;
    @(posedge MCLK);
    @(negedge MCLK);
    IO_WR    = 1'b0;
    IO_RD    = 1'b0;
    IO_ADDR  = ~a;
    IO_WDATA = ~d;
    q        = IO_RDATA;
  endtask : xfer
endmodule : rtctc_host
`default_nettype wire

// ==== rtctc_pkg.sv ====
// Functional notes
// - Tick from crystal or line divider
// - Source and line rate from control
// - Control write restarts source divider
// - Cold reset: counts undefined, alarms off
// - Relock restarts divider with fresh phase
// - All registers on I/O bus
// - Unlocked: counting stops, counts writable
// - Locked: counting runs, counts read-only
// - Reset leaves block locked and counting
// - Reset keeps time count contents
// - Binary or packed BCD per format bit
// - Seconds BCD tens 0-5, ones 0-9
// - Minutes BCD tens 0-5, ones 0-9
// - Hours 24-hour, binary 00h-17h
// - Weekday 1-7, upper nibble reads zero
// - Month day from one, 01h-1Fh
// - Leap correction only in BCD mode
// - Compare each advance and on relock
package rtctc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCTC_SEC_ADDR  = 8'hE0;
  localparam logic [7:0] RTCTC_MIN_ADDR  = 8'hE1;
  localparam logic [7:0] RTCTC_HRS_ADDR  = 8'hE2;
  localparam logic [7:0] RTCTC_DOW_ADDR  = 8'hE3;
  localparam logic [7:0] RTCTC_DOM_ADDR  = 8'hE4;
  localparam logic [7:0] RTCTC_CTRL_ADDR = 8'hEF;

  // ----------------------------------------------------------------
  // Control fields and reset value
  // ----------------------------------------------------------------
  localparam int         RTCTC_UNLOCK_BIT = 0;
  localparam int         RTCTC_BCD_BIT    = 1;
  localparam int         RTCTC_FREQ_BIT   = 2;  // 1: 50 Hz line, 0: 60 Hz line
  localparam int         RTCTC_SRC_BIT    = 3;  // 1: power line, 0: crystal
  localparam logic [7:0] RTCTC_CTRL_RST   = 8'h00;
  localparam logic [7:0] RTCTC_CTRL_MASK  = 8'h0F;

  // ----------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCTC_ZERO         = 8'h00;
  localparam logic [7:0] RTCTC_ONE          = 8'h01;
  localparam logic [7:0] RTCTC_SEC_LAST_BIN = 8'h3B;
  localparam logic [7:0] RTCTC_SEC_LAST_BCD = 8'h59;
  localparam logic [7:0] RTCTC_HRS_LAST_BIN = 8'h17;
  localparam logic [7:0] RTCTC_HRS_LAST_BCD = 8'h23;
  localparam logic [7:0] RTCTC_DOW_LAST     = 8'h07;
  localparam logic [7:0] RTCTC_DOW_MASK     = 8'h0F;
  localparam logic [7:0] RTCTC_DOM_LAST_BIN = 8'h1F;
  localparam logic [3:0] RTCTC_BCD_NINE     = 4'h9;

  // ----------------------------------------------------------------
  // Source rates, in edges per second
  // ----------------------------------------------------------------
  localparam int RTCTC_CRYSTAL_HZ = 32768;
  localparam int RTCTC_LINE50_HZ  = 50;
  localparam int RTCTC_LINE60_HZ  = 60;

  typedef enum logic {RTCTC_SRC_CRYSTAL, RTCTC_SRC_LINE} rtctc_src_t;

endpackage : rtctc_pkg

// ==== tb_rtc_time_count_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_time_count_core;
  import rtctc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  localparam int CDIV = 4;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        pwr_cold = 1'b1;
  logic        osc = 1'b0;
  logic [4:0]  md;
  logic [7:0]  io_addr, io_wdata, io_rdata;
  logic        io_wr, io_rd, cmp_stb, alarms_off;
  logic [7:0]  ctl = 8'h00;
  logic [7:0]  tv [4][5];
  logic [3:0]  bcdr = 4'h6;
  logic [31:0] rng = 32'h34313BA9;
  int          cnt [5];
  int          bad_count = 0;
  int          n_checks = 0;
  int          oscn = 0;
  int          osc_div = 0;
  bit          frc = 1'b0;

  always #10 mclk = ~mclk;

  rtctc_core #(.CRYSTAL_DIV(CDIV), .LINE50_DIV(3), .LINE60_DIV(5)) DUT (
    .MCLK(mclk), .SRST(srst), .PWR_COLD(pwr_cold), .IO_ADDR(io_addr),
    .IO_WDATA(io_wdata), .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata),
    .OSC_CLK(osc), .MONTH_DAYS(md), .CMP_STB(cmp_stb), .ALARMS_OFF(alarms_off));

  rtctc_host host (.MCLK(mclk), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
                   .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata));

  // Source input, 8 cycles a period, so edges never crowd a restart
  always @(negedge mclk) begin
    osc_div <= osc_div + 1;
    if (osc_div % 4 == 3) osc <= ~osc;
  end
  always @(posedge osc) oscn++;

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic int rnd(input int m);
    rng = xs(rng);
    return int'(rng[15:0]) % m;
  endfunction : rnd
  function automatic int bcd8(input int v);
    return v / 10 * 16 + v % 10;
  endfunction : bcd8
  function automatic int step(input int v, input bit b);
    return (b && (v & 15) == 9) ? v + 7 : v + 1;
  endfunction : step

  // Carry chain; wrap figures follow the format bit, as in the core
  task automatic m_adv();
    bit b;
    bit c0, c1, c2;
    b  = ctl[1];
    c0 = cnt[0] == (b ? 8'h59 : 8'h3B);
    c1 = c0 && cnt[1] == (b ? 8'h59 : 8'h3B);
    c2 = c1 && cnt[2] == (b ? 8'h23 : 8'h17);
    cnt[0] = c0 ? 0 : step(cnt[0], b);
    if (c0) cnt[1] = c1 ? 0 : step(cnt[1], b);
    if (c1) cnt[2] = c2 ? 0 : step(cnt[2], b);
    if (c2) cnt[3] = cnt[3] == 7 ? 1 : cnt[3] + 1;
    if (c2) cnt[4] = cnt[4] == (b ? bcd8(md) : 8'h1F) ? 1 : step(cnt[4], b);
  endtask : m_adv

  // A strobe not caused by a relock write is a count advance
  always @(posedge mclk) begin
    if (cmp_stb === 1'b1 && !frc) m_adv();
    frc <= io_wr && io_addr == RTCTC_CTRL_ADDR && !io_wdata[0];
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
    if (a == RTCTC_CTRL_ADDR) ctl = d & RTCTC_CTRL_MASK;
    else if (ctl[0] && a >= 8'hE0 && a <= 8'hE4) cnt[a - 8'hE0] = (a == 8'hE3) ? d & 8'h0F : d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    host.xfer(1'b0, a, 8'h00, q);
  endtask : rd
  // Expected value is taken after the read, so an advance in flight counts
  task automatic rcnt(input int i);
    logic [7:0] q;
    rd(8'(8'hE0 + i), q);
    chk($sformatf("count %0d", i), q, 8'(cnt[i]));
  endtask : rcnt
  task automatic wait_stb(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (cmp_stb === 1'b1) break;
    end
    if (i < lim) return;
    bad_count++;
    $display("unexpected timeout waiting for compare strobe");
    end_of_test();
  endtask : wait_stb
  // Bounded wait for one rising source edge
  task automatic wait_osc(input int lim);
    int k;
    k = oscn;
    for (int j = 0; j < lim; j++) begin
      @(negedge mclk);
      if (oscn != k) return;
    end
    bad_count++;
    $display("unexpected timeout waiting for source edge");
    end_of_test();
  endtask : wait_osc

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] q;
    md = 5'(28 + rnd(4));
    repeat (16) @(negedge mclk);
    srst     = 1'b0;
    pwr_cold = 1'b0;
    // Cold reset: locked, alarms off, unmapped reads zero
    rd(RTCTC_CTRL_ADDR, q);
    chk("control", q, 8'h00);
    chk("alarms off", {7'h00, alarms_off}, 8'h01);
    rd(8'hE7, q);
    chk("unmapped", q, 8'h00);
    $display("test reset done");
    // Load, read back, relock, one advance, read all
    tv[0] = '{8'h3B, 8'h3B, 8'h17, 8'hF7, 8'h1F};
    tv[1] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'(bcd8(md))};
    tv[2] = '{8'h59, 8'(rnd(5) * 16 + 9), 8'h19, 8'h02, 8'h29};
    tv[3] = '{8'(rnd(60)), 8'(rnd(60)), 8'(rnd(24)), 8'(1 + rnd(7)), 8'(1 + rnd(31))};
    for (int r = 0; r < 4; r++) begin
      wr(RTCTC_CTRL_ADDR, {6'h00, bcdr[r], 1'b1});
      for (int i = 0; i < 5; i++) wr(8'(8'hE0 + i), tv[r][i]);
      for (int i = 0; i < 5; i++) rcnt(i);
      wr(RTCTC_CTRL_ADDR, {6'h00, bcdr[r], 1'b0});
      chk("relock strobe", {7'h00, cmp_stb}, 8'h01);
      chk("alarms off", {7'h00, alarms_off}, 8'h00);
      wait_stb(400);
      for (int i = 0; i < 5; i++) rcnt(i);
      $display("test round %0d done", r);
    end
    // Locked writes are dropped
    wait_stb(400);
    wr(RTCTC_SEC_ADDR, 8'(cnt[0] ^ 8'h2A));
    rcnt(0);
    $display("test locked write done");
    // Edges per advance for each source, counted from the restart
    for (int s = 0; s < 3; s++) begin
      wait_osc(16);
      wr(RTCTC_CTRL_ADDR, s == 0 ? 8'h00 : (s == 1 ? 8'h0C : 8'h08));
      oscn = 0;
      wait_stb(400);
      chk("source edges", 8'(oscn), s == 0 ? 8'(CDIV) : (s == 1 ? 8'h03 : 8'h05));
    end
    $display("test sources done");
    // Warm reset keeps counts and alarm state, returns to locked
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    ctl  = 8'h00;
    for (int i = 0; i < 5; i++) rcnt(i);
    rd(RTCTC_CTRL_ADDR, q);
    chk("control", q, 8'h00);
    chk("alarms off", {7'h00, alarms_off}, 8'h00);
    $display("test warm reset done");
    end_of_test();
  end
endmodule : tb_rtc_time_count_core
`default_nettype wire
